/* File: src/adc_ctrl_defines.svh */
// register offsets, field positions, reset values of the slope adc control
// assumes a 32-bit apb bus, one aligned word per register
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ----------------------------------------
// register indices, byte address is 4x
// ----------------------------------------
`define IDX_CAP_HIGH 8'h14
`define IDX_CAP_LOW 8'h15
`define IDX_ANALOG_CONTROL 8'h1d
`define IDX_ANALOG_STATUS 8'h1e

// ----------------------------------------
// analog_control fields
// ----------------------------------------
`define CTL_CHARGE_DIR 7
`define CTL_MODE_HIGH 6
`define CTL_MODE_LOW 5
`define CTL_CAP_SEL 4
`define CTL_IRQ_EN 3
`define CTL_COMP2_PWR 2
`define CTL_COMP1_PWR 1
`define CTL_RAMP_EN 0

// ----------------------------------------
// analog_status fields
// ----------------------------------------
`define STS_COMP2_FLAG 7
`define STS_COMP1_FLAG 6
`define STS_COMP2_CLR 5
`define STS_COMP1_CLR 4
`define STS_COMP2_LEVEL 1
`define STS_COMP1_LEVEL 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_ANALOG_CONTROL 8'h00
`define RST_ANALOG_STATUS 8'h00
`define RST_CAPTURE 16'h0000

`endif

/* File: src/adc_ctrl_pkg.sv */
// types shared by the slope adc control
// assumes nothing beyond a systemverilog tool
package adc_ctrl_pkg;

  // conversion modes, value of the two-bit mode field
  typedef enum logic [1:0]
  {
    mode_manual = 2'h0,
    mode_auto_discharge = 2'h1,
    mode_overflow_capture = 2'h2,
    mode_compare_capture = 2'h3
  } conv_mode_t;

  // register selected by an apb address
  typedef enum logic [4:0]
  {
    sel_none = 5'h01,
    sel_cap_high = 5'h02,
    sel_cap_low = 5'h04,
    sel_control = 5'h08,
    sel_status = 5'h10
  } reg_sel_t;

endpackage : adc_ctrl_pkg

/* File: src/single_slope_adc_control.sv */
// control logic of a single-slope a/d converter with an apb register port
// assumes comparator outputs are asynchronous, timer flags and the
// capture pin are synchronous to pclk
//
// How it works
// - two-bit mode picks one of four modes; ignored without ramp enable; resets manual
// - ramp enable clear means no source or sink at the ramp pin
// - manual mode sinks while direction is zero, sources while one; software only
// - mode 1 clears direction on write of zero or comparator 2 flag set
// - mode 2 sets direction on overflow flag, clears it on capture flag
// - mode 3 sets direction on compare flag, clears it on capture flag
// - capture select routes comparator 2 flag, else capture pin, to capture trigger
// - writing upper mode bit one sets capture select; reset clears it
// - comparator capture stores timer value in 16-bit buffer at two addresses
// - interrupt enable requests analog interrupt while either flag set; reset clears
// - only the analog interrupt is raised, no capture interrupt; analog request persists until serviced
// - comparator 2 power follows its enable; reset clears it
// - comparator 1 power follows its enable; reset clears it
// - ramp enable powers source and discharge device; reset clears it
// - support circuitry powered while any of the three enables is set
// - comparator 2 flag set on rising output, held until cleared
// - writing one to comparator 2 clear bit clears its flag; reset too
// - reset clears every status bit
// - direction one sources, zero discharges, only with ramp enable; reads back
// - clear bits write-only, one clears, zero nothing, read zero
// - comparator 1 flag set on rising output, held until cleared
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "adc_ctrl_defines.svh"
module single_slope_adc_control
  import adc_ctrl_pkg::*;
#(
  parameter int CAP_WIDTH = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp1_out,
  input wire logic comp2_out,
  input wire logic timer_overflow_flag,
  input wire logic timer_compare_flag,
  input wire logic timer_capture_flag,
  input wire logic [CAP_WIDTH-1:0] timer_count,
  input wire logic capture_pin,
  output logic capture_trigger,
  output logic ramp_source_on,
  output logic ramp_sink_on,
  output logic ramp_power,
  output logic comp1_power,
  output logic comp2_power,
  output logic support_power,
  output logic analog_irq
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // map a byte address to a register select
  function automatic reg_sel_t decode(input logic [31:0] addr);
    reg_sel_t sel;
    sel = sel_none;
    if (addr[1:0] == 2'h0 && addr[31:10] == 22'h000000)
    begin
      case (addr[9:2])
        `IDX_CAP_HIGH: sel = sel_cap_high;
        `IDX_CAP_LOW: sel = sel_cap_low;
        `IDX_ANALOG_CONTROL: sel = sel_control;
        `IDX_ANALOG_STATUS: sel = sel_status;
        default: sel = sel_none;
      endcase
    end
    return sel;
  endfunction : decode

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic charge_direction_ff, conv_mode_high_ff, conv_mode_low_ff, capture_source_select_ff;
  logic analog_irq_enable_ff, comp2_power_enable_ff, comp1_power_enable_ff;
  logic ramp_source_enable_ff, comp1_rise_flag_ff, comp2_rise_flag_ff;
  logic [1:0] comp1_sync_ff, comp2_sync_ff;
  logic comp1_prev_ff, comp2_prev_ff, ovf_prev_ff, cmp_prev_ff, icf_prev_ff, trig_prev_ff;
  logic [CAP_WIDTH-1:0] capture_buf_ff;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic capture_trigger_ff, ramp_source_on_ff, ramp_sink_on_ff, ramp_power_ff;
  logic comp1_power_ff, comp2_power_ff, support_power_ff, analog_irq_ff;
  reg_sel_t sel;
  logic wr_en, wr_control, wr_status;
  logic comp1_rise, comp2_rise, comp2_flag_set;
  logic ovf_event, cmp_event, icf_event;
  conv_mode_t eff_mode;
  logic nxt_charge_direction, nxt_capture_trigger;
  logic [31:0] nxt_prdata;

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  // decode and write strobes, writes land in the access phase
  assign sel = decode(paddr);
  assign wr_en = psel & penable & pwrite & pready_ff;
  assign wr_control = wr_en & (sel == sel_control);
  assign wr_status = wr_en & (sel == sel_status);
  // read mux, flag-clear bits always read as zero
  always_comb
  begin
    nxt_prdata = 32'h00000000;
    case (sel)
      sel_cap_high: nxt_prdata[7:0] = capture_buf_ff[CAP_WIDTH-1 -: 8];
      sel_cap_low: nxt_prdata[7:0] = capture_buf_ff[7:0];
      sel_control:
      begin
        nxt_prdata[`CTL_CHARGE_DIR] = charge_direction_ff;
        nxt_prdata[`CTL_MODE_HIGH] = conv_mode_high_ff;
        nxt_prdata[`CTL_MODE_LOW] = conv_mode_low_ff;
        nxt_prdata[`CTL_CAP_SEL] = capture_source_select_ff;
        nxt_prdata[`CTL_IRQ_EN] = analog_irq_enable_ff;
        nxt_prdata[`CTL_COMP2_PWR] = comp2_power_enable_ff;
        nxt_prdata[`CTL_COMP1_PWR] = comp1_power_enable_ff;
        nxt_prdata[`CTL_RAMP_EN] = ramp_source_enable_ff;
      end
      sel_status:
      begin
        nxt_prdata[`STS_COMP2_FLAG] = comp2_rise_flag_ff;
        nxt_prdata[`STS_COMP1_FLAG] = comp1_rise_flag_ff;
        nxt_prdata[`STS_COMP2_LEVEL] = comp2_sync_ff[1] & comp2_power_enable_ff;
        nxt_prdata[`STS_COMP1_LEVEL] = comp1_sync_ff[1] & comp1_power_enable_ff;
      end
      default: nxt_prdata = 32'h00000000;
    endcase
  end
  // answer taken in the setup phase, ready during the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & (sel == sel_none);
      prdata_ff <= (psel & ~penable & ~pwrite) ? nxt_prdata : 32'h00000000;
    end
  end

  // ----------------------------------------
  // comparator synchronisers and edges
  // ----------------------------------------
  // two stages, edge taken from the second stage only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comp1_sync_ff <= 2'h0;
      comp2_sync_ff <= 2'h0;
      comp1_prev_ff <= 1'b0;
      comp2_prev_ff <= 1'b0;
    end
    else
    begin
      comp1_sync_ff <= {comp1_sync_ff[0], comp1_out};
      comp2_sync_ff <= {comp2_sync_ff[0], comp2_out};
      comp1_prev_ff <= comp1_sync_ff[1];
      comp2_prev_ff <= comp2_sync_ff[1];
    end
  end
  assign comp1_rise = comp1_sync_ff[1] & ~comp1_prev_ff;
  assign comp2_rise = comp2_sync_ff[1] & ~comp2_prev_ff;
  assign comp2_flag_set = comp2_rise & ~comp2_rise_flag_ff;

  // ----------------------------------------
  // comparator flags
  // ----------------------------------------
  // sticky flags, a new edge beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comp1_rise_flag_ff <= 1'b0;
      comp2_rise_flag_ff <= 1'b0;
    end
    else
    begin
      if (comp1_rise)
        comp1_rise_flag_ff <= 1'b1;
      else if (wr_status & pwdata[`STS_COMP1_CLR])
        comp1_rise_flag_ff <= 1'b0;
      if (comp2_rise)
        comp2_rise_flag_ff <= 1'b1;
      else if (wr_status & pwdata[`STS_COMP2_CLR])
        comp2_rise_flag_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // timer flag events
  // ----------------------------------------
  // rising edges of the timer flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_prev_ff <= 1'b0;
      cmp_prev_ff <= 1'b0;
      icf_prev_ff <= 1'b0;
    end
    else
    begin
      ovf_prev_ff <= timer_overflow_flag;
      cmp_prev_ff <= timer_compare_flag;
      icf_prev_ff <= timer_capture_flag;
    end
  end
  assign ovf_event = timer_overflow_flag & ~ovf_prev_ff;
  assign cmp_event = timer_compare_flag & ~cmp_prev_ff;
  assign icf_event = timer_capture_flag & ~icf_prev_ff;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // mode field acts only with the ramp source enabled
  assign eff_mode = ramp_source_enable_ff
    ? conv_mode_t'({conv_mode_high_ff, conv_mode_low_ff})
    : mode_manual;
  // charge direction, software write then automatic sequencing
  always_comb
  begin
    nxt_charge_direction = charge_direction_ff;
    if (wr_control)
      nxt_charge_direction = pwdata[`CTL_CHARGE_DIR];
    case (eff_mode)
      mode_manual: ;
      mode_auto_discharge:
      begin
        if (comp2_flag_set)
          nxt_charge_direction = 1'b0;
      end
      mode_overflow_capture:
      begin
        if (!charge_direction_ff && ovf_event)
          nxt_charge_direction = 1'b1;
        else if (charge_direction_ff && icf_event)
          nxt_charge_direction = 1'b0;
      end
      mode_compare_capture:
      begin
        if (!charge_direction_ff && cmp_event)
          nxt_charge_direction = 1'b1;
        else if (charge_direction_ff && icf_event)
          nxt_charge_direction = 1'b0;
      end
      default: nxt_charge_direction = charge_direction_ff;
    endcase
  end
  // control bits, all cleared by reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      charge_direction_ff <= 1'b0;
      conv_mode_high_ff <= 1'b0;
      conv_mode_low_ff <= 1'b0;
      capture_source_select_ff <= 1'b0;
      analog_irq_enable_ff <= 1'b0;
      comp2_power_enable_ff <= 1'b0;
      comp1_power_enable_ff <= 1'b0;
      ramp_source_enable_ff <= 1'b0;
    end
    else
    begin
      charge_direction_ff <= nxt_charge_direction;
      if (wr_control)
      begin
        conv_mode_high_ff <= pwdata[`CTL_MODE_HIGH];
        conv_mode_low_ff <= pwdata[`CTL_MODE_LOW];
        capture_source_select_ff <= pwdata[`CTL_CAP_SEL] | pwdata[`CTL_MODE_HIGH];
        analog_irq_enable_ff <= pwdata[`CTL_IRQ_EN];
        comp2_power_enable_ff <= pwdata[`CTL_COMP2_PWR];
        comp1_power_enable_ff <= pwdata[`CTL_COMP1_PWR];
        ramp_source_enable_ff <= pwdata[`CTL_RAMP_EN];
      end
    end
  end

  // ----------------------------------------
  // capture routing and buffer
  // ----------------------------------------
  // capture trigger from comparator 2 flag or the capture pin
  assign nxt_capture_trigger = capture_source_select_ff
    ? comp2_rise_flag_ff
    : capture_pin;
  // store timer value on a rising capture trigger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_prev_ff <= 1'b0;
      capture_buf_ff <= CAP_WIDTH'(`RST_CAPTURE);
    end
    else
    begin
      trig_prev_ff <= nxt_capture_trigger;
      if (nxt_capture_trigger & ~trig_prev_ff)
        capture_buf_ff <= timer_count;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // ramp drive, power enables and interrupt request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capture_trigger_ff <= 1'b0;
      ramp_source_on_ff <= 1'b0;
      ramp_sink_on_ff <= 1'b0;
      ramp_power_ff <= 1'b0;
      comp1_power_ff <= 1'b0;
      comp2_power_ff <= 1'b0;
      support_power_ff <= 1'b0;
      analog_irq_ff <= 1'b0;
    end
    else
    begin
      capture_trigger_ff <= nxt_capture_trigger;
      ramp_source_on_ff <= ramp_source_enable_ff & charge_direction_ff;
      ramp_sink_on_ff <= ramp_source_enable_ff & ~charge_direction_ff;
      ramp_power_ff <= ramp_source_enable_ff;
      comp1_power_ff <= comp1_power_enable_ff;
      comp2_power_ff <= comp2_power_enable_ff;
      support_power_ff <= ramp_source_enable_ff | comp1_power_enable_ff
        | comp2_power_enable_ff;
      analog_irq_ff <= analog_irq_enable_ff
        & (comp1_rise_flag_ff | comp2_rise_flag_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign capture_trigger = capture_trigger_ff;
  assign ramp_source_on = ramp_source_on_ff;
  assign ramp_sink_on = ramp_sink_on_ff;
  assign ramp_power = ramp_power_ff;
  assign comp1_power = comp1_power_ff;
  assign comp2_power = comp2_power_ff;
  assign support_power = support_power_ff;
  assign analog_irq = analog_irq_ff;

endmodule : single_slope_adc_control

/* File: tb/adc_ctrl_chk_sva.sv */
// port checker of the slope adc control, bound to its top module
// assumes one clock pclk and the active low reset presetn
`timescale 1ns/1ns
module adc_ctrl_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic capture_trigger,
  input wire logic ramp_source_on,
  input wire logic ramp_sink_on,
  input wire logic ramp_power,
  input wire logic comp1_power,
  input wire logic comp2_power,
  input wire logic support_power,
  input wire logic analog_irq
);
  // a completed register write
  wire logic wr_done = psel && penable && pwrite && pready;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // bus answer and read data
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  error_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  // ramp pin drive
  ramp_exclusive_a: assert property (!(ramp_source_on && ramp_sink_on))
    else $error("source and sink together");
  ramp_gated_a: assert property (ramp_source_on || ramp_sink_on |->
    ramp_power || $past(ramp_power))
    else $error("ramp driven while disabled");
  // power enables
  support_or_a: assert property (support_power == (ramp_power | comp1_power | comp2_power))
    else $error("support power mismatch");
  power_by_write_a: assert property ($changed({ramp_power, comp1_power, comp2_power}) |->
    $past(wr_done) || $past(wr_done, 2))
    else $error("power changed without write");
  reset_quiet_a: assert property (disable iff (1'h0) !presetn |->
    !(analog_irq || ramp_power || pready || support_power || capture_trigger))
    else $error("outputs active in reset");

  // main scenarios
  cover property ($rose(capture_trigger));
  cover property ($rose(analog_irq));
  cover property ($rose(ramp_source_on));
  cover property (pslverr);
endmodule : adc_ctrl_chk

bind single_slope_adc_control adc_ctrl_chk adc_ctrl_chk_i
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_trigger(capture_trigger),
  .ramp_source_on(ramp_source_on), .ramp_sink_on(ramp_sink_on), .ramp_power(ramp_power),
  .comp1_power(comp1_power), .comp2_power(comp2_power), .support_power(support_power),
  .analog_irq(analog_irq)
);

/* File: tb/analog_far_side.sv */
// model of comparators, ramp capacitor and timer flags
// assumes ramp and power controls come from the design
`timescale 1ns/1ns
module analog_far_side
#(
  parameter int PER = 200,
  parameter int CMP_AT = 9
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_on,
  input wire logic sink_on,
  input wire logic c1_pwr,
  input wire logic c2_pwr,
  input wire logic c1_level,
  input wire logic [7:0] trip,
  input wire logic cap_trig,
  output logic comp1_out,
  output logic comp2_out,
  output logic ovf,
  output logic cmpf,
  output logic capf
);
  int ramp;
  int cnt;
  logic trig_d;
  // ramp integrates, timer wraps, flags pulse for one cycle
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {ramp, cnt, trig_d, ovf, cmpf, capf} <= '0;
    end
    else
    begin
      ramp <= src_on ? ramp + 1 : (sink_on ? 0 : ramp);
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      ovf <= (cnt == PER - 1);
      cmpf <= (cnt == CMP_AT);
      trig_d <= cap_trig;
      capf <= cap_trig && !trig_d;
    end
  // powered comparators only
  assign comp1_out = c1_pwr && c1_level;
  assign comp2_out = c2_pwr && ramp > int'(trip);
endmodule : analog_far_side

/* File: tb/tb_top.sv */
// self-checking bench of the slope adc control
// assumes the far-side model and the bound checker
`timescale 1ns/1ns
`include "adc_ctrl_defines.svh"
module tb_top;
  localparam logic [7:0] CTL = `IDX_ANALOG_CONTROL;
  localparam logic [7:0] STS = `IDX_ANALOG_STATUS;
  logic pclk = 1'h0;
  logic presetn;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, capture_pin = 1'h0, c1_level = 1'h0;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic pready, pslverr, comp1_out, comp2_out, ovf, cmpf, capf, capture_trigger;
  logic ramp_source_on, ramp_sink_on, ramp_power, comp1_power, comp2_power;
  logic support_power, analog_irq;
  logic [15:0] timer_count = '0;
  logic [7:0] trip = 8'hff;
  int error_cnt = 0, cmp_count = 0;
  wire logic [2:0] mon = {capture_trigger, ramp_sink_on, ramp_source_on};
  // clock
  always #4 pclk = ~pclk;
  single_slope_adc_control single_slope_adc_control_i
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp1_out(comp1_out), .comp2_out(comp2_out), .timer_overflow_flag(ovf),
    .timer_compare_flag(cmpf), .timer_capture_flag(capf), .timer_count(timer_count),
    .capture_pin(capture_pin), .capture_trigger(capture_trigger),
    .ramp_source_on(ramp_source_on), .ramp_sink_on(ramp_sink_on), .ramp_power(ramp_power),
    .comp1_power(comp1_power), .comp2_power(comp2_power), .support_power(support_power),
    .analog_irq(analog_irq)
  );
  analog_far_side analog_far_side_i
  (
    .pclk(pclk), .presetn(presetn), .src_on(ramp_source_on), .sink_on(ramp_sink_on),
    .c1_pwr(comp1_power), .c2_pwr(comp2_power), .c1_level(c1_level), .trip(trip),
    .cap_trig(capture_trigger), .comp1_out(comp1_out), .comp2_out(comp2_out),
    .ovf(ovf), .cmpf(cmpf), .capf(capf)
  );
  // compare and count
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    output logic [32:0] rsp);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    rsp = {pslverr, prdata};
    if (n >= 20)
      error_cnt++;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [32:0] r;
    apb(1'h1, idx, v, r);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] idx, input logic [8:0] ex);
    logic [32:0] r;
    apb(1'h0, idx, 8'h0, r);
    chk(nm, r, {ex[8], 24'h0, ex[7:0]});
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask : cyc
  // bounded wait for one monitored output
  task automatic wait_on(input int b);
    int n;
    n = 0;
    while (mon[b] !== 1'h1 && n < 400)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 400)
      error_cnt++;
  endtask : wait_on
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    print_verdict();
  end
  // test sequence
  initial
  begin
    int v, m, base;
    void'($urandom(43328));
    presetn <= 1'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    rd("control", CTL, 9'h0);
    rd("status", STS, 9'h0);
    rd("capture", `IDX_CAP_HIGH, 9'h0);
    rd("unmapped", 8'h0, 9'h100);
    wr(CTL, 8'he4);
    cyc(3);
    chk("ramp off", {ramp_source_on, ramp_sink_on}, 0);
    rd("mode held", CTL, 9'hf4);
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      v = $urandom & 32'h9f;
      wr(CTL, v[7:0]);
      capture_pin <= 1'($urandom);
      cyc(3);
      chk("ramp", {ramp_power, ramp_source_on, ramp_sink_on}, {v[0], v[0] & v[7], v[0] & !v[7]});
      chk("power", {analog_irq, support_power, comp2_power, comp1_power}, {1'h0, |v[2:0], v[2:1]});
      chk("route", capture_trigger, !v[4] & capture_pin);
      rd("control", CTL, {1'h0, v[7:0]});
    end
    $display("test manual done");
    wr(CTL, 8'h0a);
    c1_level <= 1'h1;
    cyc(8);
    rd("c1 flag", STS, 9'h41);
    chk("irq", analog_irq, 1);
    wr(STS, 8'h00);
    rd("zero write", STS, 9'h41);
    wr(STS, 8'h10);
    rd("c1 clear", STS, 9'h01);
    chk("irq off", analog_irq, 0);
    c1_level <= 1'h0;
    $display("test flags done");
    for (m = 1; m < 4; m++)
    begin
      wr(CTL, 8'h05);
      wr(STS, 8'h30);
      trip <= 8'(4 + $urandom % 16);
      timer_count <= 16'($urandom);
      wr(CTL, 8'(m * 32 + ((m == 1) ? 8'h9d : 8'h05)));
      base = (m == 3) ? 10 : 0;
      wait_on(0);
      if (m > 1)
        chk("start", (analog_far_side_i.cnt - base) inside {[1:6]}, 1);
      wait_on(1);
      rd("mode", CTL, 9'(m * 32 + ((m == 1) ? 8'h1d : 8'h15)));
      chk("irq", analog_irq, m == 1);
      chk("trigger", capture_trigger, 1);
      wr(CTL, 8'h05);
      rd("c2 flag", STS, 9'h80);
      rd("cap high", `IDX_CAP_HIGH, {1'h0, timer_count[15:8]});
      rd("cap low", `IDX_CAP_LOW, {1'h0, timer_count[7:0]});
    end
    wr(STS, 8'h20);
    rd("c2 clear", STS, 9'h0);
    $display("test modes done");
    print_verdict();
  end
endmodule : tb_top
